/* design/pic_pkg.sv */
// Constants for the priority instruction control block.
// Assumes one 40 MHz system clock shared with the sequence generator.
package pic_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int INT_COUNT = 10;
    localparam int CNT_COUNT = 29;
    localparam int ADDR_W = 12;
    localparam int IDX_W = 5;
    // Start order code is held this long so that essential circuits reset
    localparam int START_HOLD_NS = 1000;
    localparam int START_HOLD_CYC = (START_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // An interrupt order not decoded back within this time means a dead interrupt path
    localparam int INT_ACK_TIMEOUT_NS = 10000;
    localparam int INT_ACK_TIMEOUT_CYC = INT_ACK_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int TMR_W = 10;
    // Vector address layout: interrupts step by four words, counters by one
    localparam logic [ADDR_W-1:0] INT_BASE_ADDR = 12'h0_004;
    localparam logic [ADDR_W-1:0] CNT_BASE_ADDR = 12'h0_024;
    localparam logic [ADDR_W-1:0] START_ADDR = 12'h0_800;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h0_000;
    typedef enum logic [1:0] {
        PIC_IDLE = 2'b00,
        PIC_START = 2'b01,
        PIC_INT = 2'b10,
        PIC_CNT = 2'b11
    } pic_state_t;
endpackage

/* design/pic_prio_pick.sv */
// Fixed-priority picker: lowest index wins.
// Assumes requests are already synchronous to the clock; purely combinational.
module pic_prio_pick #(
    parameter int N = 10
) (
    input wire logic [N-1:0] req,
    output logic [4:0] idx,
    output logic any
);
    logic [N:0] seen;
    logic [N-1:0] grant;

    // Prefix chain marks every bit above the first request as shadowed
    assign seen[0] = 1'b0;
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_chain
            assign grant[i] = req[i] & ~seen[i];
            assign seen[i+1] = seen[i] | req[i];
        end
    endgenerate
    assign any = seen[N];

    // Encode the one-hot grant
    always_comb begin
        idx = 5'h0;
        for (int k = 0; k < N; k++) begin
            if (grant[k]) begin
                idx = 5'(k);
            end
        end
    end
endmodule

/* design/pic_top.sv */
// Priority instruction control: start, interrupt and counter arbitration.
// Assumes the sequence generator marks instruction boundaries and the central
// processor returns one-hot decoded addresses on the same 40 MHz clock.
//
// Overview of operation
// - Start on trap, power dip, dead interrupts
// - Start order code forces start instruction
// - Stop time pulses while start code issued
// - Interrupt order code with twelve-bit address
// - Ten interrupt addresses, one per function
// - Fixed priority chain, cleared by decoded address
// - Counter address and instruction signal supplied
// - Counter instruction delays, never diverts program
// - Twenty-nine counters, fixed priority, decoded clear
// - Alarm when incremental pulse is lost
// - No counter instructions during voltage-fail start
module pic_top (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic TRAP_DETECT,
    input wire logic VOLTAGE_FAIL_START_REQUEST,
    input wire logic OSCILLATOR_FAIL_START_REQUEST,
    input wire logic [9:0] INT_REQ,
    input wire logic [28:0] INCR_PULSE,
    input wire logic INSTR_BOUNDARY,
    input wire logic LAST_TIME_PULSE,
    input wire logic READ_PULSE,
    input wire logic [9:0] INT_ADDR_DECODED,
    input wire logic [28:0] CNT_ADDR_DECODED,
    output logic START_ORDER_CODE,
    output logic TIME_PULSE_STOP,
    output logic INT_ORDER_CODE,
    output logic CNT_INSTRUCTION,
    output logic [11:0] WRITE_LINE_ADDR,
    output logic CNT_ALARM
);
    localparam int NI = pic_pkg::INT_COUNT;
    localparam int NC = pic_pkg::CNT_COUNT;

    pic_pkg::pic_state_t state_ff, nxt_state;
    logic [NI-1:0] int_s1_ff, int_s2_ff, int_pend_ff;
    logic [NC-1:0] cnt_s1_ff, cnt_s2_ff, cnt_s3_ff, cnt_pend_ff, cnt_edge;
    logic [2:0] st_s1_ff, st_s2_ff, st_s3_ff;
    logic [4:0] int_idx, cnt_idx, sel_ff;
    logic int_any, cnt_any, trap_rise, vfail_rise, vfail_lvl, ofail_lvl;
    logic [pic_pkg::TMR_W-1:0] tmr_ff;
    logic [pic_pkg::ADDR_W-1:0] addr_ff;
    logic watchdog, start_req, served, start_done, alarm_ff, stop_ff;

    // Two-flop synchronisers for the interrupt, counter and start request pins
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            int_s1_ff <= '0;
            int_s2_ff <= '0;
            cnt_s1_ff <= '0;
            cnt_s2_ff <= '0;
            cnt_s3_ff <= '0;
            st_s1_ff <= 3'h0;
            st_s2_ff <= 3'h0;
            st_s3_ff <= 3'h0;
        end else begin
            int_s1_ff <= INT_REQ;
            int_s2_ff <= int_s1_ff;
            cnt_s1_ff <= INCR_PULSE;
            cnt_s2_ff <= cnt_s1_ff;
            cnt_s3_ff <= cnt_s2_ff;
            st_s1_ff <= {OSCILLATOR_FAIL_START_REQUEST, VOLTAGE_FAIL_START_REQUEST, TRAP_DETECT};
            st_s2_ff <= st_s1_ff;
            st_s3_ff <= st_s2_ff;
        end
    end

    // Edges taken from the second stage only, never the first
    assign cnt_edge = cnt_s2_ff & ~cnt_s3_ff;
    assign trap_rise = st_s2_ff[0] & ~st_s3_ff[0];
    assign vfail_rise = st_s2_ff[1] & ~st_s3_ff[1];
    assign vfail_lvl = st_s2_ff[1];
    assign ofail_lvl = st_s2_ff[2];

    pic_prio_pick #(.N(NI)) u_int_pick (.req(int_pend_ff), .idx(int_idx), .any(int_any));
    pic_prio_pick #(.N(NC)) u_cnt_pick (.req(cnt_pend_ff), .idx(cnt_idx), .any(cnt_any));

    // Decoded address of the granted entry coming back means it was served
    always_comb begin
        case (state_ff)
            pic_pkg::PIC_INT: served = INT_ADDR_DECODED[sel_ff[3:0]];
            pic_pkg::PIC_CNT: served = CNT_ADDR_DECODED[sel_ff];
            default: served = 1'b0;
        endcase
    end

    // Interrupt path counts as dead when its order is never decoded back
    assign watchdog = (state_ff == pic_pkg::PIC_INT) &&
        (tmr_ff == pic_pkg::TMR_W'(pic_pkg::INT_ACK_TIMEOUT_CYC - 1));
    assign start_req = trap_rise | vfail_rise | watchdog;
    assign start_done = (state_ff == pic_pkg::PIC_START) &&
        (tmr_ff >= pic_pkg::TMR_W'(pic_pkg::START_HOLD_CYC - 1)) && LAST_TIME_PULSE;

    // Arbitration: start first, counters ahead of interrupts, one per boundary
    always_comb begin
        nxt_state = state_ff;
        if (start_req) begin
            nxt_state = pic_pkg::PIC_START;
        end else begin
            case (state_ff)
                pic_pkg::PIC_START: begin
                    if (start_done) begin
                        nxt_state = pic_pkg::PIC_IDLE;
                    end
                end
                pic_pkg::PIC_IDLE: begin
                    if (INSTR_BOUNDARY) begin
                        if (cnt_any && !vfail_lvl && !ofail_lvl) begin
                            nxt_state = pic_pkg::PIC_CNT;
                        end else if (int_any) begin
                            nxt_state = pic_pkg::PIC_INT;
                        end
                    end
                end
                pic_pkg::PIC_INT, pic_pkg::PIC_CNT: begin
                    if (served) begin
                        nxt_state = pic_pkg::PIC_IDLE;
                    end
                end
                default: nxt_state = pic_pkg::PIC_IDLE;
            endcase
        end
    end

    // Reset lands in start so power-up runs the start instruction too
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            state_ff <= pic_pkg::PIC_START;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // One timer serves both the start hold and the interrupt watchdog
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || nxt_state != state_ff) begin
            tmr_ff <= '0;
        end else if (tmr_ff != '1) begin
            tmr_ff <= tmr_ff + 1'b1;
        end
    end

    // Latch the granted index and its vector address at the boundary
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            sel_ff <= 5'h0;
            addr_ff <= pic_pkg::START_ADDR;
        end else if (nxt_state == pic_pkg::PIC_START) begin
            addr_ff <= pic_pkg::START_ADDR;
        end else if (state_ff == pic_pkg::PIC_IDLE && nxt_state == pic_pkg::PIC_CNT) begin
            sel_ff <= cnt_idx;
            addr_ff <= pic_pkg::CNT_BASE_ADDR + pic_pkg::ADDR_W'(cnt_idx);
        end else if (state_ff == pic_pkg::PIC_IDLE && nxt_state == pic_pkg::PIC_INT) begin
            sel_ff <= int_idx;
            addr_ff <= pic_pkg::INT_BASE_ADDR + pic_pkg::ADDR_W'({int_idx, 2'b00});
        end
    end

    // Pending latches: set wins over clear; start wipes all
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || state_ff == pic_pkg::PIC_START) begin
            int_pend_ff <= '0;
            cnt_pend_ff <= '0;
        end else begin
            int_pend_ff <= int_s2_ff | (int_pend_ff & ~((state_ff == pic_pkg::PIC_INT && served)
                ? INT_ADDR_DECODED : '0));
            cnt_pend_ff <= cnt_edge | (cnt_pend_ff & ~((state_ff == pic_pkg::PIC_CNT && served)
                ? CNT_ADDR_DECODED : '0));
        end
    end

    // A pulse landing on a still-pending counter is lost; sticky until start
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            alarm_ff <= 1'b0;
        end else if ((cnt_edge & cnt_pend_ff) != '0) begin
            alarm_ff <= 1'b1;
        end else if (state_ff == pic_pkg::PIC_START) begin
            alarm_ff <= 1'b0;
        end
    end

    // Timer halt asserted from the start code until the hold is over
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            stop_ff <= 1'b1;
        end else begin
            stop_ff <= (nxt_state == pic_pkg::PIC_START);
        end
    end

    assign START_ORDER_CODE = (state_ff == pic_pkg::PIC_START);
    assign TIME_PULSE_STOP = stop_ff;
    assign INT_ORDER_CODE = (state_ff == pic_pkg::PIC_INT);
    assign CNT_INSTRUCTION = (state_ff == pic_pkg::PIC_CNT);
    // Address reaches the write lines only on a read pulse, else lines idle
    assign WRITE_LINE_ADDR = READ_PULSE ? addr_ff : pic_pkg::ADDR_RESET;
    assign CNT_ALARM = alarm_ff;

    // Checks
    a_start_stops_tmr: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        START_ORDER_CODE |-> TIME_PULSE_STOP) else $error("start without timer stop");
    a_one_order_out: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $onehot0({START_ORDER_CODE, INT_ORDER_CODE, CNT_INSTRUCTION}))
        else $error("two order codes at once");
    a_trap_forces_start: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $rose(st_s2_ff[0]) |=> START_ORDER_CODE) else $error("trap did not start");
    a_start_hold_len: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $rose(START_ORDER_CODE) |-> START_ORDER_CODE [*8]) else $error("start code too short");
    a_vfail_no_cnt: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (vfail_lvl && !CNT_INSTRUCTION) |=> !CNT_INSTRUCTION) else $error("counter during vfail");
    a_int_addr_map: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (INT_ORDER_CODE && READ_PULSE) |-> (WRITE_LINE_ADDR ==
        pic_pkg::INT_BASE_ADDR + pic_pkg::ADDR_W'({sel_ff, 2'b00}))) else $error("bad interrupt addr");
    a_cnt_addr_map: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (CNT_INSTRUCTION && READ_PULSE) |-> (WRITE_LINE_ADDR ==
        pic_pkg::CNT_BASE_ADDR + pic_pkg::ADDR_W'(sel_ff))) else $error("bad counter addr");
    a_lost_pulse_alarm: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        ((cnt_edge & cnt_pend_ff) != '0) |=> CNT_ALARM ##1 (CNT_ALARM || START_ORDER_CODE))
        else $error("lost pulse not flagged");
    a_pend_held: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (int_pend_ff[0] && !served && !START_ORDER_CODE && !start_req) |=> int_pend_ff[0])
        else $error("pending interrupt dropped");
    a_int_prio_low: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (state_ff == pic_pkg::PIC_IDLE && $fell(state_ff == pic_pkg::PIC_IDLE) == 1'b0 && int_pend_ff[0]
        && INSTR_BOUNDARY && !cnt_any && !start_req) |=> (INT_ORDER_CODE && sel_ff == 5'h0))
        else $error("priority chain broken");
    a_cnt_first: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (state_ff == pic_pkg::PIC_IDLE && INSTR_BOUNDARY && cnt_any && !vfail_lvl && !ofail_lvl
        && !start_req) |=> CNT_INSTRUCTION) else $error("counter not granted");
endmodule

/* dv/pic_seq_model.sv */
// Behavioural sequence generator and central processor facing the priority control.
// Assumes the block's clock; answers each interrupt (unless muted) or counter order after a delay set by the bench.
module pic_seq_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start_oc,
    input wire logic int_oc,
    input wire logic cnt_oc,
    input wire logic tp_stop,
    input wire logic [11:0] wl_addr,
    input wire logic [7:0] dly,
    input wire logic mute,
    output logic boundary,
    output logic last_tp,
    output logic rd_pulse,
    output logic [9:0] int_dec,
    output logic [28:0] cnt_dec,
    output logic served,
    output logic [11:0] got_addr,
    output logic got_int,
    output logic [6:0] oc_reg,
    output logic [2:0] stage
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] tp;
    logic [7:0] wait_cnt;
    logic [1:0] ph;
    // Time pulses halt on the last one while the stop request stands
    always_ff @(posedge clk) begin
        if (tp_stop) tp <= 4'hb;
        else tp <= (tp == 4'hb) ? 4'h0 : tp + 4'h1;
    end
    assign last_tp = (tp == 4'hb);
    assign boundary = last_tp && !tp_stop;
    // Order code register and stage counter follow the order codes
    always_ff @(posedge clk) begin
        if (start_oc) begin
            stage <= 3'h1;
        end else if (int_oc) begin
            stage <= 3'h0;
            oc_reg <= 7'h47;
        end
    end
    // Read the address with one read pulse, then return its decode for one cycle
    always_ff @(posedge clk) begin
        rd_pulse <= 1'b0;
        int_dec <= '0;
        cnt_dec <= '0;
        served <= 1'b0;
        if (!rst_n) begin
            ph <= 2'h0;
        end else begin
            case (ph)
                2'h0: if ((int_oc && !mute) || cnt_oc) begin
                    ph <= 2'h1;
                    wait_cnt <= dly;
                end
                2'h1: if (wait_cnt != 8'h0) begin
                    wait_cnt <= wait_cnt - 8'h1;
                end else begin
                    rd_pulse <= 1'b1;
                    ph <= 2'h2;
                end
                2'h2: begin
                    got_addr <= wl_addr;
                    got_int <= int_oc;
                    served <= 1'b1;
                    if (int_oc) int_dec[(wl_addr - 12'h004) >> 2] <= 1'b1;
                    else cnt_dec[wl_addr - 12'h024] <= 1'b1;
                    ph <= 2'h3;
                end
                default: if (!int_oc && !cnt_oc) ph <= 2'h0;
            endcase
        end
    end
endmodule

/* dv/testbench.sv */
// Self-checking bench for the priority instruction control.
// Assumes the partner model stands in for the sequence generator and processor.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst_n = 0, trap = 0, vfail = 0, ofail = 0, mute = 0;
    logic [9:0] int_req = '0;
    logic [28:0] incr = '0;
    logic [7:0] dly = 8'h04;
    logic bnd, ltp, rdp, served, got_int, start_oc, tp_stop, int_oc, cnt_oc, alarm;
    logic [9:0] int_dec;
    logic [28:0] cnt_dec;
    logic [11:0] wl_addr, got_addr;
    logic [6:0] oc_reg;
    logic [2:0] stage;
    int failures = 0;
    int checks = 0;
    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;
    pic_top dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .TRAP_DETECT(trap), .VOLTAGE_FAIL_START_REQUEST(vfail),
        .OSCILLATOR_FAIL_START_REQUEST(ofail), .INT_REQ(int_req), .INCR_PULSE(incr), .INSTR_BOUNDARY(bnd),
        .LAST_TIME_PULSE(ltp), .READ_PULSE(rdp), .INT_ADDR_DECODED(int_dec), .CNT_ADDR_DECODED(cnt_dec),
        .START_ORDER_CODE(start_oc), .TIME_PULSE_STOP(tp_stop), .INT_ORDER_CODE(int_oc),
        .CNT_INSTRUCTION(cnt_oc), .WRITE_LINE_ADDR(wl_addr), .CNT_ALARM(alarm));
    pic_seq_model seq (.clk(sys_clk), .rst_n(rst_n), .start_oc(start_oc), .int_oc(int_oc), .cnt_oc(cnt_oc),
        .tp_stop(tp_stop), .wl_addr(wl_addr), .dly(dly), .mute(mute), .boundary(bnd), .last_tp(ltp),
        .rd_pulse(rdp), .int_dec(int_dec), .cnt_dec(cnt_dec), .served(served), .got_addr(got_addr),
        .got_int(got_int), .oc_reg(oc_reg), .stage(stage));
    task automatic chk_bit(string name, logic exp, logic got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic chk_val(string name, logic [11:0] exp, logic [11:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("Checks %0d, failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // Wait for the start order to end; the limit covers hold plus one time pulse cycle
    task automatic wait_start(output int n);
        n = 0;
        while (start_oc !== 1'b0 && n < 400) begin
            cyc(1);
            n++;
        end
        chk_bit("start ended", 1'b0, start_oc);
    endtask
    // Wait for the partner to finish one order, then judge what it read
    task automatic serve(logic [11:0] exp, logic is_int);
        int n;
        n = 0;
        while (served !== 1'b1 && n < 400) begin
            cyc(1);
            n++;
        end
        chk_bit("order served", 1'b1, served);
        chk_val("vector address", exp, got_addr);
        chk_bit("interrupt kind", is_int, got_int);
        cyc(1);
    endtask
    // Pulse long enough to pass the input synchronisers
    task automatic pulse(int i);
        incr[i] = 1'b1;
        cyc(3);
        incr[i] = 1'b0;
    endtask
    task automatic t_reset();
        int n;
        cyc(5);
        chk_bit("start in reset", 1'b1, start_oc);
        chk_bit("stop in reset", 1'b1, tp_stop);
        cyc(15);
        rst_n = 1'b1;
        wait_start(n);
        chk_bit("start hold", 1'b1, n >= 40);
        chk_val("stage after start", 12'h001, {9'h0, stage});
        chk_bit("stop released", 1'b0, tp_stop);
        $display("reset test done");
    endtask
    task automatic t_ints();
        for (int i = 0; i < 10; i++) begin
            int_req[i] = 1'b1;
            cyc(5);
            int_req[i] = 1'b0;
            serve(12'h004 + 12'(4 * i), 1'b1);
        end
        chk_val("order code register", 12'h047, {5'h0, oc_reg});
        int_req = 10'h084;
        cyc(5);
        int_req = '0;
        serve(12'h00c, 1'b1);
        serve(12'h020, 1'b1);
        $display("interrupt test done");
    endtask
    task automatic t_cnts();
        for (int i = 0; i < 29; i++) begin
            pulse(i);
            serve(12'h024 + 12'(i), 1'b0);
        end
        int_req[9] = 1'b1;
        incr = 29'h1000_0001;
        cyc(5);
        incr = '0;
        int_req = '0;
        serve(12'h024, 1'b0);
        serve(12'h040, 1'b0);
        serve(12'h028, 1'b1);
        $display("counter test done");
    endtask
    // A slow answer leaves the first pulse pending when the second arrives
    task automatic t_alarm();
        dly = 8'h28;
        chk_bit("alarm idle", 1'b0, alarm);
        pulse(5);
        cyc(3);
        pulse(5);
        cyc(3);
        chk_bit("alarm on lost pulse", 1'b1, alarm);
        serve(12'h029, 1'b0);
        dly = 8'h04;
        $display("alarm test done");
    endtask
    task automatic t_vfail();
        int n;
        vfail = 1'b1;
        cyc(6);
        chk_bit("start on voltage fail", 1'b1, start_oc);
        wait_start(n);
        chk_bit("alarm cleared by start", 1'b0, alarm);
        pulse(1);
        int_req[0] = 1'b1;
        cyc(5);
        int_req[0] = 1'b0;
        serve(12'h004, 1'b1);
        cyc(100);
        chk_bit("counter held off", 1'b0, cnt_oc);
        vfail = 1'b0;
        serve(12'h025, 1'b0);
        $display("voltage fail test done");
    endtask
    // Oscillator fail only holds counters off and must not start the computer;
    // a slow answer keeps a wrongly granted counter visible at the check
    task automatic t_ofail();
        dly = 8'h50;
        ofail = 1'b1;
        cyc(3);
        pulse(2);
        cyc(40);
        chk_bit("no start on osc fail", 1'b0, start_oc);
        chk_bit("counter held by osc fail", 1'b0, cnt_oc);
        ofail = 1'b0;
        serve(12'h026, 1'b0);
        dly = 8'h04;
        $display("oscillator fail test done");
    endtask
    task automatic t_trap();
        int n;
        trap = 1'b1;
        cyc(6);
        chk_bit("start on trap", 1'b1, start_oc);
        chk_bit("stop with start", 1'b1, tp_stop);
        trap = 1'b0;
        wait_start(n);
        $display("trap test done");
    endtask
    // The partner never decodes the interrupt, so the block must restart
    task automatic t_dead();
        int n;
        mute = 1'b1;
        int_req[3] = 1'b1;
        cyc(5);
        int_req[3] = 1'b0;
        n = 0;
        while (start_oc !== 1'b1 && n < 600) begin
            cyc(1);
            n++;
        end
        chk_bit("start on dead interrupt", 1'b1, start_oc);
        mute = 1'b0;
        wait_start(n);
        $display("dead interrupt test done");
    endtask
    initial begin
        t_reset();
        t_ints();
        t_cnts();
        t_alarm();
        t_vfail();
        t_ofail();
        t_trap();
        t_dead();
        end_sim();
    end
    // Watchdog far beyond the few thousand cycles the tests need
    initial begin
        #1000000;
        failures++;
        end_sim();
    end
endmodule
